// >>> design/i2c_master_end.sv
// Two-wire bus master: register write and combined-format read sequences.
// Assumes the slave may stretch SCL; SCL is divided from clk_sys.
`timescale 1ns/10ps
module i2c_master_end #(
  parameter int QUARTER_CYC = i2c_pkg::QUARTER_CYC
) (
  // Two-wire link
  i2c_link_if.master link,
  // Clock and reset
  input logic clk_sys,
  input logic sys_rst,
  // Command
  input logic cmd_valid,
  input logic cmd_rw,
  input logic [6:0] cmd_dev_addr,
  input logic [7:0] cmd_sub,
  input logic [7:0] cmd_len,
  output logic cmd_ready,
  // Write data
  input logic [7:0] wdata,
  input logic wdata_valid,
  output logic wdata_ready,
  // Read data and status
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic done,
  output logic nack
);
  localparam int QW = $clog2(QUARTER_CYC + 1);
  localparam logic [QW-1:0] QMAX = QW'(QUARTER_CYC - 1);

  // ==========================================================
  // Line sampling
  logic [1:0] line_s;
  wire scl_s = line_s[1];
  wire sda_s = line_s[0];

  sync2 #(.WIDTH(2), .RST_VAL(2'h3)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d_in({link.scl, link.sda}),
    .q_out(line_s)
  );

  // ==========================================================
  // State
  i2c_pkg::mst_state_t state_r;
  i2c_pkg::mst_state_t state_nxt;
  logic [QW-1:0] qcnt_r;
  logic [QW-1:0] qcnt_nxt;
  logic [1:0] ph_r;
  logic [1:0] ph_nxt;
  logic [3:0] slot_r;
  logic [3:0] slot_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] rem_r;
  logic [7:0] rem_nxt;
  logic [6:0] dev_r;
  logic [6:0] dev_nxt;
  logic [7:0] sub_r;
  logic [7:0] sub_nxt;
  logic rw_r;
  logic rw_nxt;
  logic load_r;
  logic load_nxt;
  logic nbit_r;
  logic nbit_nxt;
  logic scl_low_r;
  logic sda_low_r;
  logic ready_r;
  logic ready_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic done_r;
  logic done_nxt;
  logic nack_r;
  logic nack_nxt;

  // ==========================================================
  // Quarter-bit engine; phase 2 waits while SCL is held low
  wire running = (state_r != i2c_pkg::MST_IDLE);
  wire adv = running & (qcnt_r == QMAX) & ~load_r & ~((ph_r == 2'h2) & ~scl_s);
  wire sample = adv & (ph_r == 2'h2);
  wire slot_end = adv & (ph_r == 2'h3);
  wire ack_slot = (slot_r == i2c_pkg::ACK_SLOT);
  wire last_byte = (rem_r == 8'h01);
  wire is_send = (state_r == i2c_pkg::MST_ADDR) | (state_r == i2c_pkg::MST_SUB) |
                 (state_r == i2c_pkg::MST_WDATA) | (state_r == i2c_pkg::MST_RADDR);
  wire is_start = (state_r == i2c_pkg::MST_START) | (state_r == i2c_pkg::MST_RSTART);
  wire sda_want = (is_start & (ph_r == 2'h3)) |
                  ((state_r == i2c_pkg::MST_STOP) & (ph_r != 2'h3)) |
                  ((state_r == i2c_pkg::MST_RDATA) & ack_slot & ~last_byte) |
                  (is_send & ~ack_slot & ~shift_r[7]);
  wire sda_ok = scl_low_r | (ph_r != 2'h0);

  always_comb
  begin
    state_nxt = state_r;
    qcnt_nxt = (qcnt_r != QMAX) ? qcnt_r + QW'(1) : (adv ? '0 : qcnt_r);
    ph_nxt = adv ? ph_r + 2'h1 : ph_r;
    slot_nxt = slot_r;
    shift_nxt = shift_r;
    rem_nxt = rem_r;
    dev_nxt = dev_r;
    sub_nxt = sub_r;
    rw_nxt = rw_r;
    load_nxt = load_r;
    nbit_nxt = nbit_r;
    ready_nxt = ready_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    done_nxt = 1'b0;
    nack_nxt = nack_r;
    if (!running)
    begin
      qcnt_nxt = '0;
      ph_nxt = 2'h0;
    end
    if (load_r && wdata_valid)
    begin
      shift_nxt = wdata;
      load_nxt = 1'b0;
    end
    if (sample && ack_slot)
    begin
      nbit_nxt = sda_s;
    end
    else if (sample && state_r == i2c_pkg::MST_RDATA)
    begin
      shift_nxt = {shift_r[6:0], sda_s};
    end
    if (slot_end)
    begin
      slot_nxt = ack_slot ? 4'h0 : slot_r + 4'h1;
      if (is_send && !ack_slot)
      begin
        shift_nxt = {shift_r[6:0], 1'b0};
      end
    end
    unique case (state_r)
      i2c_pkg::MST_IDLE:
      begin
        if (cmd_valid && ready_r)
        begin
          state_nxt = i2c_pkg::MST_START;
          dev_nxt = cmd_dev_addr;
          sub_nxt = cmd_sub;
          rw_nxt = cmd_rw;
          rem_nxt = cmd_len;
          ready_nxt = 1'b0;
          nack_nxt = 1'b0;
          slot_nxt = 4'h0;
        end
      end
      i2c_pkg::MST_START:
      begin
        if (slot_end)
        begin
          state_nxt = i2c_pkg::MST_ADDR;
          shift_nxt = {dev_r, 1'b0};
          slot_nxt = 4'h0;
        end
      end
      i2c_pkg::MST_ADDR:
      begin
        if (slot_end && ack_slot)
        begin
          state_nxt = nbit_r ? i2c_pkg::MST_STOP : i2c_pkg::MST_SUB;
          nack_nxt = nbit_r;
          shift_nxt = sub_r;
        end
      end
      i2c_pkg::MST_SUB:
      begin
        if (slot_end && ack_slot)
        begin
          state_nxt = nbit_r ? i2c_pkg::MST_STOP : (rw_r ? i2c_pkg::MST_RSTART : i2c_pkg::MST_WDATA);
          nack_nxt = nbit_r;
          load_nxt = ~nbit_r & ~rw_r;
        end
      end
      i2c_pkg::MST_WDATA:
      begin
        if (slot_end && ack_slot)
        begin
          state_nxt = (nbit_r | last_byte) ? i2c_pkg::MST_STOP : i2c_pkg::MST_WDATA;
          nack_nxt = nbit_r;
          load_nxt = ~nbit_r & ~last_byte;
          rem_nxt = rem_r - 8'h01;
        end
      end
      i2c_pkg::MST_RSTART:
      begin
        if (slot_end)
        begin
          state_nxt = i2c_pkg::MST_RADDR;
          shift_nxt = {dev_r, 1'b1};
          slot_nxt = 4'h0;
        end
      end
      i2c_pkg::MST_RADDR:
      begin
        if (slot_end && ack_slot)
        begin
          state_nxt = nbit_r ? i2c_pkg::MST_STOP : i2c_pkg::MST_RDATA;
          nack_nxt = nbit_r;
        end
      end
      i2c_pkg::MST_RDATA:
      begin
        if (slot_end && ack_slot)
        begin
          rdata_nxt = shift_r;
          rvalid_nxt = 1'b1;
          rem_nxt = rem_r - 8'h01;
          state_nxt = last_byte ? i2c_pkg::MST_STOP : i2c_pkg::MST_RDATA;
        end
      end
      i2c_pkg::MST_STOP:
      begin
        if (slot_end)
        begin
          state_nxt = i2c_pkg::MST_IDLE;
          done_nxt = 1'b1;
          ready_nxt = 1'b1;
        end
      end
      default:
      begin
        state_nxt = i2c_pkg::MST_IDLE;
        ready_nxt = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_r <= i2c_pkg::MST_IDLE;
      qcnt_r <= '0;
      ph_r <= 2'h0;
      slot_r <= 4'h0;
      shift_r <= 8'h00;
      rem_r <= 8'h00;
      dev_r <= 7'h00;
      sub_r <= 8'h00;
      rw_r <= 1'b0;
      load_r <= 1'b0;
      nbit_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      ready_r <= 1'b1;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      done_r <= 1'b0;
      nack_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      qcnt_r <= qcnt_nxt;
      ph_r <= ph_nxt;
      slot_r <= slot_nxt;
      shift_r <= shift_nxt;
      rem_r <= rem_nxt;
      dev_r <= dev_nxt;
      sub_r <= sub_nxt;
      rw_r <= rw_nxt;
      load_r <= load_nxt;
      nbit_r <= nbit_nxt;
      scl_low_r <= running & (ph_r == 2'h0);
      sda_low_r <= sda_ok ? (running & sda_want) : sda_low_r;
      ready_r <= ready_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      done_r <= done_nxt;
      nack_r <= nack_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign link.m_scl_o = 1'b0;
  assign link.m_sda_o = 1'b0;
  assign link.m_scl_oe = scl_low_r;
  assign link.m_sda_oe = sda_low_r;
  assign cmd_ready = ready_r;
  assign wdata_ready = load_r;
  assign rdata = rdata_r;
  assign rdata_valid = rvalid_r;
  assign done = done_r;
  assign nack = nack_r;
endmodule

// >>> design/i2c_slave_end.sv
// Two-wire register slave: address match, sub-address pointer, burst read and write.
// Assumes the link pins are asynchronous and are oversampled by clk_sys.
`timescale 1ns/10ps
module i2c_slave_end (
  // Two-wire link
  i2c_link_if.slave link,
  // Clock and reset
  input logic clk_sys,
  input logic sys_rst,
  // Pins
  input logic iface_sel,
  input logic address_lsb_select,
  input logic core_power_good,
  // Local control
  input logic stretch_req,
  // Status and register side
  output logic busy,
  output logic wr_pulse,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wire_mode_select,
  output logic spi_enable,
  output logic measure_enable
);
  // ==========================================================
  // Pin synchronisation and line events
  logic [4:0] pin_s;
  logic scl_d_r;
  logic sda_d_r;
  wire scl_s;
  wire sda_s;
  wire sel_s;
  wire lsb_s;
  wire pwr_s;

  sync2 #(.WIDTH(5), .RST_VAL(5'h1f)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d_in({link.scl, link.sda, iface_sel, address_lsb_select, core_power_good}),
    .q_out(pin_s)
  );

  assign scl_s = pin_s[4];
  assign sda_s = pin_s[3];
  assign sel_s = pin_s[2];
  assign lsb_s = pin_s[1];
  assign pwr_s = pin_s[0];

  // Oversampling at 200 MHz covers both bus rates
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_seen = sel_s & scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_seen = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ==========================================================
  // State
  i2c_pkg::slv_state_t state_r;
  i2c_pkg::slv_state_t state_nxt;
  i2c_pkg::slv_phase_t phase_r;
  i2c_pkg::slv_phase_t phase_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [6:0] ptr_r;
  logic [6:0] ptr_nxt;
  logic rw_r;
  logic rw_nxt;
  logic inc_r;
  logic inc_nxt;
  logic sda_oe_r;
  logic sda_oe_nxt;
  logic hold_r;
  logic hold_nxt;
  logic mack_r;
  logic mack_nxt;
  logic busy_r;
  logic busy_nxt;
  logic wr_pulse_r;
  logic wr_pulse_nxt;
  logic [6:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic wire_mode_r;
  logic spi_en_r;
  logic meas_en_r;
  logic [7:0] reg_file_r [i2c_pkg::REG_COUNT];

  function automatic logic [6:0] ptr_step(input logic [6:0] p);
    return (p == i2c_pkg::PRESS_LAST) ? i2c_pkg::PRESS_FIRST : p + 7'h01;
  endfunction

  // ==========================================================
  // Decoding
  wire [6:0] own_addr = {i2c_pkg::ADDR_HI, lsb_s};
  wire addr_hit = (shift_r[7:1] == own_addr);
  wire [7:0] rd_byte = reg_file_r[ptr_r];
  wire [6:0] ptr_adv = inc_r ? ptr_step(ptr_r) : ptr_r;
  wire byte_done = scl_fall & (cnt_r == i2c_pkg::ACK_SLOT);

  // ==========================================================
  // Protocol sequencer
  always_comb
  begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    inc_nxt = inc_r;
    sda_oe_nxt = sda_oe_r;
    hold_nxt = hold_r & stretch_req;
    mack_nxt = mack_r;
    busy_nxt = busy_r;
    wr_pulse_nxt = 1'b0;
    if (!sel_s)
    begin
      state_nxt = i2c_pkg::SLV_IDLE;
      sda_oe_nxt = 1'b0;
      hold_nxt = 1'b0;
      busy_nxt = 1'b0;
    end
    else if (start_seen)
    begin
      state_nxt = i2c_pkg::SLV_RX;
      phase_nxt = i2c_pkg::PH_ADDR;
      cnt_nxt = 4'h0;
      sda_oe_nxt = 1'b0;
      hold_nxt = 1'b0;
      busy_nxt = 1'b1;
    end
    else if (stop_seen)
    begin
      state_nxt = i2c_pkg::SLV_IDLE;
      sda_oe_nxt = 1'b0;
      hold_nxt = 1'b0;
      busy_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        i2c_pkg::SLV_IDLE:
        begin
        end
        i2c_pkg::SLV_RX:
        begin
          if (scl_rise)
          begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (byte_done)
          begin
            cnt_nxt = 4'h0;
            state_nxt = i2c_pkg::SLV_ACK;
            sda_oe_nxt = 1'b1;
            hold_nxt = stretch_req;
            if (phase_r == i2c_pkg::PH_ADDR)
            begin
              rw_nxt = shift_r[0];
              if (!addr_hit)
              begin
                state_nxt = i2c_pkg::SLV_IGNORE;
                sda_oe_nxt = 1'b0;
                hold_nxt = 1'b0;
              end
            end
            else if (phase_r == i2c_pkg::PH_SUB)
            begin
              ptr_nxt = shift_r[6:0];
              inc_nxt = shift_r[i2c_pkg::SUB_INC_BIT];
              phase_nxt = i2c_pkg::PH_DATA;
            end
            else
            begin
              wr_pulse_nxt = 1'b1;
              ptr_nxt = ptr_adv;
            end
          end
        end
        i2c_pkg::SLV_ACK:
        begin
          if (scl_fall)
          begin
            sda_oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            state_nxt = i2c_pkg::SLV_RX;
            if (phase_r == i2c_pkg::PH_ADDR && rw_r)
            begin
              state_nxt = i2c_pkg::SLV_TX;
              shift_nxt = rd_byte;
              sda_oe_nxt = ~rd_byte[7];
            end
            else if (phase_r == i2c_pkg::PH_ADDR)
            begin
              phase_nxt = i2c_pkg::PH_SUB;
            end
          end
        end
        i2c_pkg::SLV_TX:
        begin
          if (scl_fall && cnt_r == i2c_pkg::TX_LAST)
          begin
            sda_oe_nxt = 1'b0;
            state_nxt = i2c_pkg::SLV_MACK;
            ptr_nxt = ptr_adv;
          end
          else if (scl_fall)
          begin
            cnt_nxt = cnt_r + 4'h1;
            shift_nxt = {shift_r[6:0], 1'b0};
            sda_oe_nxt = ~shift_r[6];
          end
        end
        i2c_pkg::SLV_MACK:
        begin
          if (scl_rise)
          begin
            mack_nxt = ~sda_s;
          end
          else if (scl_fall && mack_r)
          begin
            state_nxt = i2c_pkg::SLV_TX;
            cnt_nxt = 4'h0;
            shift_nxt = rd_byte;
            sda_oe_nxt = ~rd_byte[7];
          end
          else if (scl_fall)
          begin
            state_nxt = i2c_pkg::SLV_IGNORE;
          end
        end
        i2c_pkg::SLV_IGNORE:
        begin
          sda_oe_nxt = 1'b0;
        end
        default:
        begin
          state_nxt = i2c_pkg::SLV_IDLE;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_r <= i2c_pkg::SLV_IDLE;
      phase_r <= i2c_pkg::PH_ADDR;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 7'h00;
      rw_r <= 1'b0;
      inc_r <= 1'b0;
      sda_oe_r <= 1'b0;
      hold_r <= 1'b0;
      mack_r <= 1'b0;
      busy_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      inc_r <= inc_nxt;
      sda_oe_r <= sda_oe_nxt;
      hold_r <= hold_nxt;
      mack_r <= mack_nxt;
      busy_r <= busy_nxt;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Register file and user-side status
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < i2c_pkg::REG_COUNT; i++)
      begin
        reg_file_r[i] <= i2c_pkg::REG_RESET;
      end
      wr_pulse_r <= 1'b0;
      wr_addr_r <= 7'h00;
      wr_data_r <= 8'h00;
      wire_mode_r <= 1'b0;
      spi_en_r <= 1'b0;
      meas_en_r <= 1'b0;
    end
    else
    begin
      if (wr_pulse_nxt)
      begin
        reg_file_r[ptr_r] <= shift_r;
        wr_addr_r <= ptr_r;
        wr_data_r <= shift_r;
      end
      wr_pulse_r <= wr_pulse_nxt;
      wire_mode_r <= reg_file_r[i2c_pkg::CTRL1_ADDR][i2c_pkg::WIRE_MODE_BIT];
      spi_en_r <= ~sel_s;
      meas_en_r <= pwr_s;
    end
  end

  // ==========================================================
  // Outputs
  assign link.s_scl_o = 1'b0;
  assign link.s_sda_o = 1'b0;
  assign link.s_scl_oe = hold_r;
  assign link.s_sda_oe = sda_oe_r;
  assign busy = busy_r;
  assign wr_pulse = wr_pulse_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;
  assign wire_mode_select = wire_mode_r;
  assign spi_enable = spi_en_r;
  assign measure_enable = meas_en_r;
endmodule

// >>> design/sync2.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent level; no bus coherency.
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // Clock and reset
  input logic clk_sys,
  input logic sys_rst,
  // Levels
  input logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule

// >>> shared/i2c_link_if.sv
// Two-wire link between bus master and register slave.
// Open-drain lines with pull-ups; each party drives low through its enable.
`timescale 1ns/10ps
interface i2c_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_scl_o;
  logic s_scl_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // ==========================================================
  // Wired-AND resolution with pull-ups
  assign scl = (m_scl_oe ? m_scl_o : 1'b1) & (s_scl_oe ? s_scl_o : 1'b1);
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport master (
    input scl,
    input sda,
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe
  );

  modport slave (
    input scl,
    input sda,
    output s_scl_o,
    output s_scl_oe,
    output s_sda_o,
    output s_sda_oe
  );
endinterface

// >>> shared/i2c_pkg.sv
// Shared constants and types for the two-wire register port and its bus master.
// Assumes a 200 MHz system clock on both ends.
package i2c_pkg;

  // ==========================================================
  // Addressing
  localparam logic [5:0] ADDR_HI = 6'h2e;
  localparam int SUB_INC_BIT = 7;
  localparam logic [6:0] PRESS_FIRST = 7'h28;
  localparam logic [6:0] PRESS_LAST = 7'h2a;
  localparam logic [6:0] CTRL1_ADDR = 7'h20;
  localparam int WIRE_MODE_BIT = 0;
  localparam int REG_COUNT = 128;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================
  // Bit counting
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_FREQ_KHZ = 400;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_FREQ_KHZ;
  localparam int QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // ==========================================================
  // State machines
  typedef enum logic [2:0] {
    SLV_IDLE = 3'h0,
    SLV_RX = 3'h1,
    SLV_ACK = 3'h3,
    SLV_TX = 3'h2,
    SLV_MACK = 3'h6,
    SLV_IGNORE = 3'h4
  } slv_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_SUB = 2'h1,
    PH_DATA = 2'h3
  } slv_phase_t;

  typedef enum logic [3:0] {
    MST_IDLE = 4'h0,
    MST_START = 4'h1,
    MST_ADDR = 4'h3,
    MST_SUB = 4'h2,
    MST_WDATA = 4'h6,
    MST_RSTART = 4'h7,
    MST_RADDR = 4'h5,
    MST_RDATA = 4'h4,
    MST_STOP = 4'hc
  } mst_state_t;

endpackage

// >>> verification/i2c_link_asserts.sv
// Checker on the link lines between the joined master and slave ends.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module i2c_link_asserts (
  // Clock and reset
  input logic clk_sys,
  input logic sys_rst,
  // Link
  input logic scl,
  input logic sda,
  input logic m_sda_oe,
  input logic s_scl_oe,
  input logic s_sda_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // ==========
  // Slave link timing
  sda_edge_a:
    assert property ($changed(s_sda_oe) |-> !scl) else $error("slave data moved with clock high");
  stretch_ack_a:
    assert property ($rose(s_scl_oe) |-> s_sda_oe) else $error("stretch outside ack");
  stretch_end_a:
    assert property ($rose(s_scl_oe) |-> ##[1:300] !s_scl_oe) else $error("stretch never released");
  sda_bound_a:
    assert property ($rose(s_sda_oe) |-> ##[1:400] !s_sda_oe) else $error("slave holds data line");
  start_free_a:
    assert property (scl && $fell(sda) |-> !s_sda_oe) else $error("slave pulls data at start");
  stop_idle_a:
    assert property (scl && $rose(sda) |=> !s_sda_oe [*8]) else $error("slave active after stop");
  no_fight_a:
    assert property (scl |-> !(m_sda_oe && s_sda_oe)) else $error("both drive data, clock high");
  scl_run_a:
    assert property ($fell(scl) |-> ##[1:300] scl) else $error("clock stuck low");
  cover property ($rose(s_scl_oe));
  cover property (scl && $rose(sda));
  cover property (s_sda_oe && $rose(scl));
endmodule

// >>> verification/testbench.sv
// Bench: master end and slave end joined by the link, driven from the command side.
// Assumes the shared link interface and the link checker.
`timescale 1ns/10ps
module testbench;
  int wi = 0, ri = 0, nw = 0, n_mismatch = 0, checked = 0;
  logic took_r = 1'b0;
  logic cmd_ready, wr_pulse;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0, cmd_rw = 1'b0;
  logic [6:0] cmd_dev_addr = 7'h00;
  logic [7:0] cmd_sub = 8'h00, cmd_len = 8'h01;
  logic iface_sel = 1'b1, address_lsb_select = 1'b1, core_power_good = 1'b1, stretch_req = 1'b0;
  logic wdata_ready, rdata_valid, done, nack, busy, wire_mode_select, spi_enable, measure_enable;
  logic [7:0] rdata, wr_data;
  logic [6:0] wr_addr;
  logic [7:0] rbuf [8];
  logic [7:0] wbuf [8] = '{8'ha5, 8'h3c, 8'h0f, 8'h01, 8'h02, 8'h03, 8'h01, 8'h00};
  wire [7:0] wdata = wbuf[wi];

  always #2.5 clk_sys = ~clk_sys;

  i2c_link_if link();
  i2c_master_end #(.QUARTER_CYC(8)) i_i2c_master_end (.link, .clk_sys, .sys_rst, .cmd_valid, .cmd_rw,
    .cmd_dev_addr, .cmd_sub, .cmd_len, .cmd_ready, .wdata, .wdata_valid(1'b1), .wdata_ready, .rdata,
    .rdata_valid, .done, .nack);
  i2c_slave_end i_i2c_slave_end (.link, .clk_sys, .sys_rst, .iface_sel, .address_lsb_select,
    .core_power_good, .stretch_req, .busy, .wr_pulse, .wr_addr, .wr_data, .wire_mode_select,
    .spi_enable, .measure_enable);
  i2c_link_asserts i_i2c_link_asserts (.clk_sys, .sys_rst, .scl(link.scl), .sda(link.sda),
    .m_sda_oe(link.m_sda_oe), .s_scl_oe(link.s_scl_oe), .s_sda_oe(link.s_sda_oe));

  // ==========
  // Write data supply and read capture
  // Next write byte shown only after the master has taken the current one
  always @(negedge clk_sys)
  begin
    took_r <= wdata_ready;
    if (took_r)
      wi <= wi + 1;
    if (wr_pulse)
      nw <= nw + 1;
    if (rdata_valid)
    begin
      rbuf[ri] <= rdata;
      ri <= ri + 1;
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] s, input logic [7:0] n, input int w0);
    int t;
    @(negedge clk_sys);
    wi = w0;
    ri = 0;
    nw = 0;
    cmd_valid = 1'b1;
    cmd_rw = rw;
    cmd_dev_addr = a;
    cmd_sub = s;
    cmd_len = n;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (t = 0; t < 9000 && done !== 1'b1; t++)
      @(negedge clk_sys);
    if (t == 9000)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask

  // ==========
  // Main sequence
  initial
  begin
    int t;
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("idle lines", 8'h03, {6'h00, link.scl, link.sda});
    xfer(1'b0, 7'h5d, 8'h90, 8'h03, 0);
    chk("nack", 8'h00, 8'(nack));
    chk("wr_addr", 8'h12, 8'(wr_addr));
    chk("wr_data", 8'h0f, wr_data);
    chk("busy", 8'h00, 8'(busy));
    chk("write pulses", 8'h03, 8'(nw));
    chk("cmd_ready", 8'h01, 8'(cmd_ready));
    xfer(1'b1, 7'h5d, 8'h90, 8'h03, 0);
    chk("read count", 8'h03, 8'(ri));
    for (int i = 0; i < 3; i++)
      chk("read back", wbuf[i], rbuf[i]);
    $display("end burst");
    xfer(1'b0, 7'h5d, 8'h05, 8'h02, 0);
    chk("wr_addr", 8'h05, 8'(wr_addr));
    xfer(1'b1, 7'h5d, 8'h05, 8'h02, 0);
    for (int i = 0; i < 2; i++)
      chk("fixed read", 8'h3c, rbuf[i]);
    $display("end fixed pointer");
    xfer(1'b0, 7'h5d, 8'ha9, 8'h03, 3);
    xfer(1'b1, 7'h5d, 8'ha8, 8'h04, 0);
    for (int i = 0; i < 4; i++)
      chk("wrap read", wbuf[3 + (i + 2) % 3], rbuf[i]);
    $display("end wrap");
    for (int p = 0; p < 2; p++)
    begin
      address_lsb_select = p[0];
      repeat (4) @(negedge clk_sys);
      xfer(1'b0, 7'h5c ^ 7'(p), 8'h20, 8'h01, 7 - p);
      chk("match nack", 8'h00, 8'(nack));
      chk("wire mode", 8'(wbuf[7 - p][0]), 8'(wire_mode_select));
      for (int q = 0; q < 2; q++)
      begin
        xfer(1'b0, (q != 0 ? 7'h1c : 7'h5d) ^ 7'(p), 8'h20, 8'h01, 6 + p);
        chk("miss nack", 8'h01, 8'(nack));
        chk("wire mode", 8'(wbuf[7 - p][0]), 8'(wire_mode_select));
      end
    end
    $display("end address");
    iface_sel = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("spi_enable", 8'h01, 8'(spi_enable));
    xfer(1'b0, 7'h5d, 8'h20, 8'h01, 6);
    chk("spi nack", 8'h01, 8'(nack));
    iface_sel = 1'b1;
    core_power_good = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("measure", 8'h00, 8'(measure_enable));
    xfer(1'b1, 7'h5d, 8'h90, 8'h01, 0);
    chk("read", 8'ha5, rbuf[0]);
    core_power_good = 1'b1;
    $display("end select");
    stretch_req = 1'b1;
    fork
      xfer(1'b0, 7'h5d, 8'h11, 8'h01, 3);
      begin
        for (t = 0; t < 4000 && link.s_scl_oe !== 1'b1; t++)
          @(negedge clk_sys);
        if (t == 4000)
        begin
          n_mismatch++;
          complete_run();
        end
        repeat (40) @(negedge clk_sys);
        chk("stretch", 8'h02, {6'h00, link.s_scl_oe, link.scl});
        stretch_req = 1'b0;
      end
    join
    chk("wr_data", 8'h01, wr_data);
    chk("measure", 8'h01, 8'(measure_enable));
    chk("spi_enable", 8'h00, 8'(spi_enable));
    $display("end stretch");
    complete_run();
  end
endmodule
